// ---- src/tdmps_pkg.sv ----
/*
  Shared constants for the TDM switch port pin-select front end:
  register offsets, control and status field positions, frame lengths.
  Assumes a 32-bit APB register bus with byte addresses.
*/
package tdmps_pkg;
  // Register byte offsets
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_CHSEL = 12'h004;
  localparam logic [11:0] REG_STATUS = 12'h008;
  localparam logic [11:0] REG_DATA = 12'h00C;
  // Control field positions, register reset values and status overrun bit
  localparam int CTRL_W = 18;
  localparam int CTRL_MUX = 0;
  localparam int CTRL_RATE_LO = 1;
  localparam int CTRL_RATE_HI = 2;
  localparam int CTRL_16X8 = 3;
  localparam int CTRL_NIB = 4;
  localparam int CTRL_CLK8 = 5;
  localparam int CTRL_CONST = 6;
  localparam int CTRL_OFS_LO = 8;
  localparam int CTRL_OFS_HI = 17;
  localparam logic [17:0] CTRL_RST = 18'h00000;
  localparam logic [15:0] CHSEL_RST = 16'h0000;
  localparam int STAT_OVR = 2;
  // Stream rate codes in the control register
  localparam logic [1:0] RATE_2M = 2'h0;
  localparam logic [1:0] RATE_4M = 2'h1;
  localparam logic [1:0] RATE_8M = 2'h2;
  localparam logic [1:0] RATE_4M_8X4 = 2'h3;
  // Last bit index of a frame: 32, 64 or 128 channels of 8 bits
  localparam logic [9:0] FRAME_LAST_2M = 10'h0FF;
  localparam logic [9:0] FRAME_LAST_4M = 10'h1FF;
  localparam logic [9:0] FRAME_LAST_8M = 10'h3FF;
  // Channel capacity of the switch core
  localparam int CH_NONBLOCK = 256;
  localparam int CH_BLOCK = 512;
  // Serial clock edges a level must hold to count as frame idle
  localparam logic [3:0] IDLE_RUN = 4'h8;
  localparam int NUM_LANES = 14;
  // Frame pulse recogniser states
  typedef enum logic {SYNC_HUNT, SYNC_LOCK} tdmps_sync_t;
endpackage

// ---- src/tdmps_lane.sv ----
/*
  One serial input lane: shifts a stream bit on each bit tick and
  presents the finished unit (byte, or nibble in the low bits).
  Assumes bit tick and unit end come from the shared frame counter.
*/
`timescale 1ns/1ps
`default_nettype none
module tdmps_lane (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  // Timing strobes
  input wire logic bit_tick_in,
  input wire logic unit_end_in,
  // Serial data
  input wire logic serial_in,
  output logic [7:0] unit_out
);
  logic [6:0] shift_r;

  // Shift in and hand over the unit at its last bit
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      shift_r <= 7'h00;
      unit_out <= 8'h00;
    end else if (bit_tick_in) begin
      shift_r <= {shift_r[5:0], serial_in};
      if (unit_end_in) begin
        unit_out <= {shift_r, serial_in};
      end
    end
  end
endmodule
`default_nettype wire

// ---- src/tdmps_fifo.sv ----
/*
  Small synchronous FIFO with valid/ready on both sides.
  Assumes DEPTH is a power of two; read data comes from the array.
*/
`timescale 1ns/1ps
`default_nettype none
module tdmps_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  wire do_wr = in_valid && in_ready;
  wire do_rd = out_valid && out_ready;

  // Honest flags from the occupancy count
  assign in_ready = (count_r != (AW+1)'(DEPTH));
  assign out_valid = (count_r != '0);
  assign out_data = mem[rd_ptr_r];

  // Storage carries no reset
  always_ff @(posedge clk_sys_in) begin
    if (do_wr) begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  // Pointers and count
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (do_wr) wr_ptr_r <= wr_ptr_r + 1'b1;
      if (do_rd) rd_ptr_r <= rd_ptr_r + 1'b1;
      if (do_wr && !do_rd) count_r <= count_r + 1'b1;
      else if (do_rd && !do_wr) count_r <= count_r - 1'b1;
    end
  end
endmodule
`default_nettype wire

// ---- src/tdmps_port_select.sv ----
/*
  Serial input front end of a TDM switch: frame pulse recognition,
  bit timing from the serial clock, 14 input lanes, shared pin
  selection between stream inputs and host address, host transfer
  acknowledge, and channel capture into a FIFO read over APB.
  Assumes every pin input is synchronous to clk_sys_in, and the
  serial clock is slow enough to be sampled as a level.
*/
`timescale 1ns/1ps
`default_nettype none
module tdmps_port_select import tdmps_pkg::*; #(
  parameter int FIFO_DEPTH = 8
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Serial side
  input wire logic serial_clk_in,
  input wire logic frame_sync_in,
  input wire logic [5:0] serial_in_low_group_in,
  input wire logic serial_in6_or_addr6_in,
  input wire logic serial_in7_or_addr7_in,
  input wire logic [2:0] addr_low_or_serial_in_8_10_in,
  input wire logic [2:0] addr_mid_or_serial_in_11_13_in,
  output logic [13:0] stream_active_out,
  // Host bus
  input wire logic host_cs_n_in,
  input wire logic host_strobe_in,
  input wire logic host_ale_in,
  input wire logic [7:0] host_data_lines_in,
  output logic [7:0] host_addr_out,
  output logic transfer_ack_n_out,
  output logic transfer_ack_n_oe_out
);
  logic [CTRL_W-1:0] ctrl_r;
  logic [15:0] chsel_r;
  logic sel_a6_r, sel_a7_r, sel_hi_r;
  logic sclk_q_r, fs_q_r, idle_lvl_r;
  logic [3:0] run_r;
  tdmps_sync_t sync_r;
  logic [1:0] div_r;
  logic [9:0] bit_cnt_r;
  logic cap_hit_r, hold_v_r, pend_r, ovr_r, ack_r, ack_oe_r;
  logic [7:0] hold_r, pend_data_r, addr_r;
  logic [31:0] rdata_r;
  logic [NUM_LANES-1:0] lane_in;
  logic [7:0] lane_unit [NUM_LANES];
  logic fifo_in_ready, fifo_out_valid;
  logic [7:0] fifo_out_data;

  // Control fields
  wire mux_bus = ctrl_r[CTRL_MUX];
  wire [1:0] rate_cfg = ctrl_r[CTRL_RATE_HI:CTRL_RATE_LO];
  wire cfg_16x8 = ctrl_r[CTRL_16X8];
  wire nibble = ctrl_r[CTRL_NIB];
  wire clk8 = ctrl_r[CTRL_CLK8];
  wire const_dly = ctrl_r[CTRL_CONST];
  wire [9:0] offset = ctrl_r[CTRL_OFS_HI:CTRL_OFS_LO];

  // Rate level 0/1/2 for 2.048/4.096/8.192; 16x8 forces 2.048
  wire rate_is_8m = (rate_cfg == RATE_8M);
  wire rate_is_4m = (rate_cfg == RATE_4M) || (rate_cfg == RATE_4M_8X4);
  wire [1:0] rate_lvl = cfg_16x8 ? 2'h0 : rate_is_8m ? 2'h2 :
                        rate_is_4m ? 2'h1 : 2'h0;
  // Clock edges per bit: 8.192 MHz clock gives twice the 4.096 ratio
  wire [1:0] base_lvl = clk8 ? 2'h2 : 2'h1;
  wire rate_bad = (rate_lvl > base_lvl);
  wire [1:0] ratio_log = rate_bad ? 2'h0 : 2'(base_lvl - rate_lvl);
  wire [1:0] div_last = (ratio_log == 2'h2) ? 2'h3 :
                        (ratio_log == 2'h1) ? 2'h1 : 2'h0;
  wire [9:0] frame_last = (rate_lvl == 2'h2) ? FRAME_LAST_8M :
                          (rate_lvl == 2'h1) ? FRAME_LAST_4M :
                          FRAME_LAST_2M;

  // Pin functions, recomputed only from the held configuration
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sel_a6_r <= 1'b0;
      sel_a7_r <= 1'b0;
      sel_hi_r <= 1'b0;
    end else begin
      sel_a6_r <= !mux_bus && !cfg_16x8 &&
                  (rate_is_8m || rate_cfg == RATE_4M);
      sel_a7_r <= !mux_bus && !cfg_16x8 && rate_is_8m;
      sel_hi_r <= cfg_16x8;
    end
  end
  assign stream_active_out = {{6{sel_hi_r}}, !sel_a7_r, !sel_a6_r,
                              6'h3F};

  // Serial clock and frame pulse sampling
  wire sclk_rise = serial_clk_in && !sclk_q_r;
  wire locked = (sync_r == SYNC_LOCK);
  wire frame_start = sclk_rise && locked &&
                     (frame_sync_in != idle_lvl_r) &&
                     (fs_q_r == idle_lvl_r);

  // Pulse format is told by the idle level: high idle means an
  // active-low pulse, low idle means an active-high one
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sclk_q_r <= 1'b0;
      fs_q_r <= 1'b1;
      run_r <= 4'h0;
      idle_lvl_r <= 1'b1;
      sync_r <= SYNC_HUNT;
    end else begin
      sclk_q_r <= serial_clk_in;
      if (sclk_rise) begin
        fs_q_r <= frame_sync_in;
        if (frame_sync_in != fs_q_r) run_r <= 4'h0;
        else if (run_r != IDLE_RUN) run_r <= run_r + 4'h1;
        case (sync_r)
          SYNC_HUNT: begin
            if (run_r == IDLE_RUN) begin
              idle_lvl_r <= fs_q_r;
              sync_r <= SYNC_LOCK;
            end
          end
          SYNC_LOCK: begin
            if (run_r == IDLE_RUN && fs_q_r != idle_lvl_r) begin
              sync_r <= SYNC_HUNT; // Format changed, hunt again
            end
          end
          default: sync_r <= SYNC_HUNT;
        endcase
      end
    end
  end

  // Bit timing; the frame pulse reloads the programmed offset
  wire bit_tick = sclk_rise && locked && !frame_start &&
                  (div_r == div_last);
  wire unit_end = bit_tick &&
                  (nibble ? &bit_cnt_r[1:0] : &bit_cnt_r[2:0]);
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      div_r <= 2'h0;
      bit_cnt_r <= 10'h000;
    end else if (frame_start) begin
      div_r <= 2'h0;
      bit_cnt_r <= offset & frame_last;
    end else if (sclk_rise) begin
      div_r <= (div_r == div_last) ? 2'h0 : div_r + 2'h1;
      if (bit_tick) begin
        bit_cnt_r <= (bit_cnt_r == frame_last) ? 10'h000 :
                     bit_cnt_r + 10'h001;
      end
    end
  end

  // Lanes; shared pins feed lanes whether or not they are streams
  assign lane_in = {addr_mid_or_serial_in_11_13_in,
                    addr_low_or_serial_in_8_10_in,
                    serial_in7_or_addr7_in, serial_in6_or_addr6_in,
                    serial_in_low_group_in};
  for (genvar i = 0; i < NUM_LANES; i++) begin : g_lane
    tdmps_lane u_lane (
      .clk_sys_in(clk_sys_in),
      .sys_rst_in(sys_rst_in),
      .bit_tick_in(bit_tick),
      .unit_end_in(unit_end),
      .serial_in(lane_in[i]),
      .unit_out(lane_unit[i])
    );
  end

  // Channel match; unit index spans 256 nibbles or 128 bytes
  wire [3:0] sel_stream = chsel_r[3:0];
  wire stream_ok = (sel_stream < 4'(NUM_LANES)) &&
                   stream_active_out[sel_stream];
  wire [7:0] unit_idx = nibble ? bit_cnt_r[9:2] :
                        {1'b0, bit_cnt_r[9:3]};
  wire cap_hit = unit_end && stream_ok && (unit_idx == chsel_r[15:8]);
  wire [7:0] cap_data = nibble ? {4'h0, lane_unit[sel_stream][3:0]} :
                        lane_unit[sel_stream];
  // Constant delay releases at the next frame, variable at once
  wire push_req = const_dly ? (frame_start && hold_v_r) : cap_hit_r;
  wire [7:0] push_data = const_dly ? hold_r : cap_data;

  // Lane units settle one cycle after unit end, so capture waits
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cap_hit_r <= 1'b0;
      hold_v_r <= 1'b0;
      hold_r <= 8'h00;
    end else begin
      cap_hit_r <= cap_hit;
      if (cap_hit_r && const_dly) begin
        hold_r <= cap_data;
        hold_v_r <= 1'b1;
      end else if (frame_start) begin
        hold_v_r <= 1'b0;
      end
    end
  end

  // Pending word waits while the FIFO is full; a capture then is dropped and sets overrun
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pend_r <= 1'b0;
      pend_data_r <= 8'h00;
    end else if (push_req && (!pend_r || fifo_in_ready)) begin
      pend_r <= 1'b1;
      pend_data_r <= push_data;
    end else if (fifo_in_ready) begin
      pend_r <= 1'b0;
    end
  end
  wire ovr_set = push_req && pend_r && !fifo_in_ready;

  // APB decode; one wait state so read data comes from a flop
  wire apb_acc = psel_in && penable_in;
  wire apb_done = apb_acc && ack_r;
  wire hit_ctrl = (paddr_in == REG_CTRL);
  wire hit_chsel = (paddr_in == REG_CHSEL);
  wire hit_stat = (paddr_in == REG_STATUS);
  wire hit_data = (paddr_in == REG_DATA);
  wire hit_any = hit_ctrl || hit_chsel || hit_stat || hit_data;
  wire wr_ctrl = apb_done && pwrite_in && hit_ctrl;
  wire wr_chsel = apb_done && pwrite_in && hit_chsel;
  wire wr_stat = apb_done && pwrite_in && hit_stat;
  wire pop = apb_done && !pwrite_in && hit_data;
  wire [31:0] status_w = {23'h0, rate_bad, sel_hi_r, sel_a7_r,
                          sel_a6_r, !fifo_in_ready, !fifo_out_valid,
                          ovr_r, locked, !idle_lvl_r};
  wire [31:0] rd_mux = hit_ctrl ? {14'h0, ctrl_r} :
                       hit_chsel ? {16'h0, chsel_r} :
                       hit_stat ? status_w :
                       hit_data ? {24'h0, fifo_out_data} : 32'h0;
  assign pready_out = apb_done;
  assign pslverr_out = apb_done && !hit_any;
  assign prdata_out = rdata_r;

  // Bus handshake and read data
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ack_r <= 1'b0;
      rdata_r <= 32'h0;
    end else begin
      ack_r <= apb_acc && !ack_r;
      if (apb_acc && !ack_r) rdata_r <= rd_mux;
    end
  end

  // Registers; overrun set wins over a write-one clear
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ctrl_r <= CTRL_RST;
      chsel_r <= CHSEL_RST;
      ovr_r <= 1'b0;
    end else begin
      if (wr_ctrl) ctrl_r <= pwdata_in[CTRL_W-1:0];
      if (wr_chsel) chsel_r <= pwdata_in[15:0];
      if (ovr_set) ovr_r <= 1'b1;
      else if (wr_stat && pwdata_in[STAT_OVR]) ovr_r <= 1'b0;
    end
  end

  tdmps_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in),
    .in_valid(pend_r),
    .in_ready(fifo_in_ready),
    .in_data(pend_data_r),
    .out_valid(fifo_out_valid),
    .out_ready(pop),
    .out_data(fifo_out_data)
  );

  // Host address: latched from data lines or taken from shared pins
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      addr_r <= 8'h00;
    end else if (mux_bus) begin
      if (host_ale_in) addr_r <= host_data_lines_in;
    end else begin
      addr_r <= {sel_a7_r & serial_in7_or_addr7_in,
                 sel_a6_r & serial_in6_or_addr6_in,
                 addr_mid_or_serial_in_11_13_in & {3{!sel_hi_r}},
                 addr_low_or_serial_in_8_10_in &
                 {3{!sel_hi_r}}};
    end
  end
  assign host_addr_out = addr_r;

  // Acknowledge drives low from the selected strobe until chip select releases
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ack_oe_r <= 1'b0;
    end else if (host_cs_n_in) begin
      ack_oe_r <= 1'b0;
    end else if (host_strobe_in) begin
      ack_oe_r <= 1'b1;
    end
  end
  assign transfer_ack_n_out = 1'b0; // Open drain, only pulls low
  assign transfer_ack_n_oe_out = ack_oe_r;

  // Checks
  chk_a6_select: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in) ##1 sel_a6_r == (!$past(mux_bus) &&
    !$past(cfg_16x8) && ($past(rate_cfg) == RATE_8M ||
    $past(rate_cfg) == RATE_4M)))
    else $error("pin 6 function wrong");
  chk_a7_select: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in) sel_a7_r |-> sel_a6_r &&
    !stream_active_out[7])
    else $error("pin 7 address without pin 6");
  chk_low_pins: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in) (sel_hi_r && !mux_bus) |=>
    host_addr_out[5:0] == 6'h00)
    else $error("stream pins leaked into address");
  chk_pin_static: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in) $stable(ctrl_r) |=>
    $stable({sel_a6_r, sel_a7_r, sel_hi_r}))
    else $error("pin function moved without config change");
  chk_ack_release: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in) host_cs_n_in |=>
    !transfer_ack_n_oe_out)
    else $error("acknowledge held without select");
  chk_ack_drive: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in) (!host_cs_n_in && host_strobe_in)
    |=> transfer_ack_n_oe_out && !transfer_ack_n_out)
    else $error("acknowledge not driven low");
  chk_mux_latch: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in) (mux_bus && host_ale_in) |=>
    host_addr_out == $past(host_data_lines_in))
    else $error("multiplexed address not latched");
  chk_frame_wrap: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in) bit_cnt_r <= frame_last)
    else $error("bit count beyond frame");
  chk_offset_load: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in) frame_start |=>
    bit_cnt_r == ($past(offset) & $past(frame_last)))
    else $error("frame offset not applied");
  chk_const_delay: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in) (const_dly && push_req) |->
    frame_start)
    else $error("constant delay pushed mid frame");
  chk_sync_format: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in) frame_start |-> locked &&
    $past(fs_q_r) == idle_lvl_r)
    else $error("frame start without recognised format");
  cov_gci: cover property (@(posedge clk_sys_in)
    disable iff (sys_rst_in) frame_start && !idle_lvl_r);
  cov_capture: cover property (@(posedge clk_sys_in)
    disable iff (sys_rst_in) pop && fifo_out_valid);
  cov_overrun: cover property (@(posedge clk_sys_in)
    disable iff (sys_rst_in) ovr_set);
endmodule
`default_nettype wire

// ---- dv/tdmps_tdm_src.sv ----
/*
  Serial stream source: serial clock, frame pulse, one data bit.
  Assumes 2.048 Mb/s data on a 4.096 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module tdmps_tdm_src (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  // Mode
  input wire logic gci_in,
  input wire logic [7:0] pattern_in,
  // Serial outputs
  output logic serial_clk_out,
  output logic frame_sync_out,
  output logic data_out
);
  logic [10:0] tick_r;
  // Four system clocks per serial clock keep level sampling safe
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      tick_r <= 11'h000;
    end else begin
      tick_r <= tick_r + 11'h001;
    end
  end
  // 512 serial clocks per frame, 32 channels
  assign serial_clk_out = tick_r[1];
  // Pulse in the last clock, polarity by format
  assign frame_sync_out = (tick_r[10:2] == 9'h1FF) ^ !gci_in;
  // MSB first; changes at the falling serial edge
  assign data_out = pattern_in[3'h7 - tick_r[5:3]];
endmodule
`default_nettype wire

// ---- dv/tb_top.sv ----
/*
  Testbench for the port select front end: APB master, host bus,
  serial source. Assumes the design's own assertions run alongside.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import tdmps_pkg::*;
  logic clk_sys_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, er, gci = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, sclk, fsync, sd, use_ser = 1'b0;
  logic cs_n = 1'b1, strobe = 1'b0, ale = 1'b0, oe, ack_n;
  logic [7:0] pins = 8'h00, hdata = 8'h00, haddr;
  logic [7:0] pat = 8'hB1;
  logic [13:0] act;
  logic [17:0] c;
  int num_errors = 0;
  int check_count = 0;
  // Address pins carry stream data from the capture tests to the end of the run
  wire logic [7:0] pv = use_ser ? {8{sd}} : pins;

  always #10 clk_sys_in = ~clk_sys_in;

  tdmps_port_select #(.FIFO_DEPTH(8)) dut (
    .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
    .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr),
    .serial_clk_in(sclk), .frame_sync_in(fsync),
    .serial_in_low_group_in({6{sd}}), .serial_in6_or_addr6_in(pv[6]),
    .serial_in7_or_addr7_in(pv[7]),
    .addr_low_or_serial_in_8_10_in(pv[2:0]),
    .addr_mid_or_serial_in_11_13_in(pv[5:3]),
    .stream_active_out(act), .host_cs_n_in(cs_n),
    .host_strobe_in(strobe), .host_ale_in(ale),
    .host_data_lines_in(hdata), .host_addr_out(haddr),
    .transfer_ack_n_out(ack_n), .transfer_ack_n_oe_out(oe));

  tdmps_tdm_src src (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
    .gci_in(gci), .pattern_in(pat), .serial_clk_out(sclk),
    .frame_sync_out(fsync), .data_out(sd));

  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One APB transfer; waits for pready with no assumed latency
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys_in);
    penable <= 1'b1;
    @(posedge clk_sys_in);
    while (pready !== 1'b1) @(posedge clk_sys_in);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [13:0] exp_act(input logic [17:0] k);
    logic a6, a7;
    a6 = !k[0] && !k[3] && (k[2:1] == RATE_4M || k[2:1] == RATE_8M);
    a7 = !k[0] && !k[3] && k[2:1] == RATE_8M;
    return {{6{k[3]}}, !a7, !a6, 6'h3F};
  endfunction

  function automatic logic [7:0] exp_addr(input logic [17:0] k);
    logic [13:0] a;
    a = exp_act(k);
    return k[0] ? hdata : pins & {!a[7], !a[6], {6{!k[3]}}};
  endfunction

  // Any rotation of the pattern, since frame alignment is not pinned
  function automatic logic rot_ok(input logic [31:0] v, input int w);
    logic [15:0] r;
    for (int i = 0; i < 8; i++) begin
      r = {pat, pat} >> i;
      if (w == 8 && v === {24'h000000, r[7:0]}) return 1'b1;
      if (w == 4 && v === {28'h0000000, r[3:0]}) return 1'b1;
    end
    return 1'b0;
  endfunction

  task frames(input int n);
    repeat (n * 2048) @(posedge clk_sys_in);
  endtask

  task close_out;
    $display("Checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Cut a hang short; the run needs some 40000 cycles
  initial begin
    repeat (90000) @(posedge clk_sys_in);
    num_errors++;
    close_out();
  end

  initial begin
    void'($urandom(32));
    repeat (4) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    apb(1'b0, REG_CTRL, 32'h0);
    chk("ctrl_rst", 32'(CTRL_RST), rd);
    chk("act_rst", 32'h00FF, 32'(act));
    apb(1'b0, 12'h010, 32'h0);
    chk("bad_err", 32'h1, 32'(er));
    // Park capture on a refused lane while modes are swept
    apb(1'b1, REG_CHSEL, 32'h000F);
    // Every bus mode, rate code and 16x8 setting
    for (int m = 0; m < 16; m++) begin
      c = {10'($urandom), 4'h0, 4'(m)};
      pins <= 8'($urandom);
      hdata <= 8'($urandom);
      apb(1'b1, REG_CTRL, 32'(c));
      apb(1'b0, REG_CTRL, 32'h0);
      chk("ctrl", 32'(c), rd);
      ale <= 1'b1;
      @(posedge clk_sys_in);
      ale <= 1'b0;
      repeat (3) @(posedge clk_sys_in);
      chk("active", 32'(exp_act(c)), 32'(act));
      chk("addr", 32'(exp_addr(c)), 32'(haddr));
    end
    // Host transfer acknowledge
    cs_n <= 1'b0;
    strobe <= 1'b1;
    @(posedge clk_sys_in);
    @(posedge clk_sys_in);
    chk("ack_on", 32'h1, 32'(oe));
    chk("ack_lvl", 32'h0, 32'(ack_n));
    cs_n <= 1'b1;
    strobe <= 1'b0;
    @(posedge clk_sys_in);
    @(posedge clk_sys_in);
    chk("ack_off", 32'h0, 32'(oe));
    // Capture with low-pulse framing, all fourteen lanes as streams
    use_ser <= 1'b1;
    apb(1'b1, REG_CTRL, 32'h8);
    apb(1'b1, REG_CHSEL, {16'h0, 8'($urandom_range(31)), 4'h0,
      4'($urandom_range(13))});
    frames(3);
    apb(1'b0, REG_STATUS, 32'h0);
    chk("lock", 32'h2, rd & 32'h3);
    apb(1'b0, REG_DATA, 32'h0);
    chk("unit", 32'h1, 32'(rot_ok(rd, 8)));
    frames(9);
    apb(1'b1, REG_CHSEL, 32'h000F);
    apb(1'b0, REG_STATUS, 32'h0);
    chk("full_ovr", 32'h14, rd & 32'h1C);
    // Drain eight stored words plus the pending one
    repeat (9) begin
      apb(1'b0, REG_DATA, 32'h0);
      chk("drain", 32'h1, 32'(rot_ok(rd, 8)));
    end
    apb(1'b1, REG_STATUS, 32'h4);
    apb(1'b0, REG_STATUS, 32'h0);
    chk("empty", 32'h8, rd & 32'h1C);
    // Nibble units on lane 0, held to the next frame
    apb(1'b1, REG_CTRL, 32'h58);
    apb(1'b1, REG_CHSEL, 32'h0300);
    frames(3);
    apb(1'b0, REG_DATA, 32'h0);
    chk("nibble", 32'h1, 32'(rot_ok(rd, 4)));
    // High-pulse framing is told apart by itself
    sys_rst_in <= 1'b1;
    gci <= 1'b1;
    repeat (4) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    frames(3);
    apb(1'b0, REG_STATUS, 32'h0);
    chk("gci", 32'h3, rd & 32'h3);
    close_out();
  end
endmodule
`default_nettype wire
